// [core/pie_ctrl.sv]
// Function
// - with priority off, a source needs group enable plus its own enable
// - priority bits matter only while the priority scheme is enabled
// - enable 1 bits 7..0: parallel, adc, rx, tx, sync serial, ccp1, tmr2, tmr1
// - enable 2 bits 7..0: osc, comparator, zero, nvm, collision, voltage, tmr3, ccp2
// - every implemented enable bit is read/write, 1 enables, 0 disables
// - priority bits align with enable 1 bits, 1 high, 0 low
// - small package: parallel enable and priority read zero
// - reset clears enables and sets priorities
// - flags latch on conditions regardless of enables
// - priority scheme enable is bit 7 of reset control register
//
// Purpose: peripheral interrupt enable and priority masking with avalon slave
// Assumes: source events are one-cycle synchronous pulses
// Notes:   flags are cleared by writing ones; set wins over clear
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "pie_defs.svh"
module pie_ctrl
  import pie_pkg::*;
#(
  parameter bit SMALL_PKG = 1'b0           // parallel port absent
)(
  input  wire logic        mclk,           // core clock 250 MHz
  input  wire logic        rst,            // async reset, active high
  input  wire logic [5:0]  address,        // avalon byte address
  input  wire logic        read,           // avalon read
  input  wire logic        write,          // avalon write
  input  wire logic [31:0] writedata,      // avalon write data
  input  wire logic [3:0]  byteenable,     // avalon byte enables
  output logic      [31:0] readdata,       // avalon read data
  output logic             waitrequest,    // avalon stall
  input  wire logic [7:0]  src_evt_1,      // group 1 condition pulses
  input  wire logic [7:0]  src_evt_2,      // group 2 condition pulses
  output logic             irq_high,       // high vector request
  output logic             irq_low,        // low vector request
  output logic             irq             // status/mask interrupt
);
  logic [7:0] en1, en2, prio1, ctrl, flg1, flg2;
  logic [2:0] ist, imask;
  logic [7:0] next_en1, next_en2, next_prio1, next_ctrl, next_flg1, next_flg2;
  logic [2:0] next_ist, next_imask;
  logic [31:0] next_readdata;
  logic        next_waitrequest, next_irq_high, next_irq_low, next_irq;
  pie_bus_e    st, next_st;
  logic [7:0] impl1, rh1, rl1, rs1, rh2, rl2, rs2;
  logic       wr_go, rd_go, any_h, any_l, any_s, glb;

  // implemented bits of group 1 depend on package
  assign impl1 = SMALL_PKG ? `PIE_EN1_IMPL_SMALL : `PIE_EN1_IMPL_FULL;
  assign glb   = ctrl[`PIE_CTRL_GLOBAL];

  pie_gate u_g1 (
    .flags      (flg1),
    .enables    (en1),
    .prios      (prio1),
    .prio_en    (ctrl[`PIE_CTRL_PRIO_EN]),
    .group_en   (ctrl[`PIE_CTRL_GROUP]),
    .req_high   (rh1),
    .req_low    (rl1),
    .req_single (rs1)
  );
  // group 2 priorities live outside this block; treated as high
  pie_gate u_g2 (
    .flags      (flg2),
    .enables    (en2),
    .prios      (8'hFF),
    .prio_en    (ctrl[`PIE_CTRL_PRIO_EN]),
    .group_en   (ctrl[`PIE_CTRL_GROUP]),
    .req_high   (rh2),
    .req_low    (rl2),
    .req_single (rs2)
  );
  assign any_h = |{rh1, rh2};
  assign any_l = |{rl1, rl2};
  assign any_s = |{rs1, rs2};

  // one-cycle wait then ack, so reads come from registered data
  assign wr_go = write & (st == PIE_ACK);
  assign rd_go = read & (st == PIE_IDLE);

  // bus handshake and register updates
  always_comb begin
    next_st          = st;
    next_waitrequest = 1'b1;
    next_en1   = en1;
    next_en2   = en2;
    next_prio1 = prio1;
    next_ctrl  = ctrl;
    next_imask = imask;
    next_readdata = readdata;
    unique case (st)
      PIE_IDLE: begin
        if (read || write) begin
          next_st          = PIE_ACK;
          next_waitrequest = 1'b0;
        end
      end
      PIE_ACK: begin
        next_st = PIE_IDLE;
      end
    endcase
    if (rd_go) begin
      unique case (address)
        `PIE_OFS_ENABLE_1:   next_readdata = {24'h000000, en1 & impl1};
        `PIE_OFS_ENABLE_2:   next_readdata = {24'h000000, en2 & `PIE_EN2_IMPL};
        `PIE_OFS_PRIORITY_1: next_readdata = {24'h000000, prio1 & impl1};
        `PIE_OFS_CONTROL:    next_readdata = {24'h000000, ctrl};
        `PIE_OFS_FLAGS:      next_readdata = {16'h0000, flg2, flg1};
        `PIE_OFS_IRQ_STATUS: next_readdata = {29'h0, ist};
        `PIE_OFS_IRQ_MASK:   next_readdata = {29'h0, imask};
        default:             next_readdata = 32'h00000000;
      endcase
    end
    // writes stored this edge, effective for masking next cycle
    if (wr_go && byteenable[0]) begin
      unique case (address)
        `PIE_OFS_ENABLE_1:   next_en1   = writedata[7:0] & impl1;
        `PIE_OFS_ENABLE_2:   next_en2   = writedata[7:0] & `PIE_EN2_IMPL;
        `PIE_OFS_PRIORITY_1: next_prio1 = writedata[7:0] | ~impl1;
        `PIE_OFS_CONTROL:    next_ctrl  = writedata[7:0] & `PIE_CTRL_IMPL;
        `PIE_OFS_IRQ_MASK:   next_imask = writedata[2:0];
        default:             next_imask = imask;
      endcase
    end
  end

  // flags and sticky status: set beats write-one-to-clear
  always_comb begin
    next_flg1 = flg1;
    next_flg2 = flg2;
    next_ist  = ist;
    if (wr_go && byteenable[0] && address == `PIE_OFS_FLAGS)
      next_flg1 = flg1 & ~writedata[7:0];
    if (wr_go && byteenable[1] && address == `PIE_OFS_FLAGS)
      next_flg2 = flg2 & ~writedata[15:8];
    if (wr_go && byteenable[0] && address == `PIE_OFS_IRQ_STATUS)
      next_ist = ist & ~writedata[2:0];
    next_flg1 = (next_flg1 | src_evt_1) & impl1;
    next_flg2 = (next_flg2 | src_evt_2) & `PIE_EN2_IMPL;
    next_ist[`PIE_EVT_HIGH]   = next_ist[`PIE_EVT_HIGH] | (any_h & ~irq_high);
    next_ist[`PIE_EVT_LOW]    = next_ist[`PIE_EVT_LOW] | (any_l & ~irq_low);
    next_ist[`PIE_EVT_SINGLE] = next_ist[`PIE_EVT_SINGLE] | (any_s & ~irq_high);
    // vectoring outputs, gated by the global enable
    next_irq_high = glb & (any_h | any_s);
    next_irq_low  = glb & any_l & ~any_h;
    next_irq      = |(next_ist & imask);
  end

  // registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st          <= PIE_IDLE;
      waitrequest <= 1'b1;
      readdata    <= 32'h00000000;
      en1         <= `PIE_EN1_RESET;
      en2         <= `PIE_EN2_RESET;
      prio1       <= `PIE_PRIO1_RESET;
      ctrl        <= `PIE_CTRL_RESET;
      imask       <= 3'h0;
      flg1        <= 8'h00;
      flg2        <= 8'h00;
      ist         <= 3'h0;
      irq_high    <= 1'b0;
      irq_low     <= 1'b0;
      irq         <= 1'b0;
    end else begin
      st          <= next_st;
      waitrequest <= next_waitrequest;
      readdata    <= next_readdata;
      en1         <= next_en1;
      en2         <= next_en2;
      prio1       <= next_prio1;
      ctrl        <= next_ctrl;
      imask       <= next_imask;
      flg1        <= next_flg1;
      flg2        <= next_flg2;
      ist         <= next_ist;
      irq_high    <= next_irq_high;
      irq_low     <= next_irq_low;
      irq         <= next_irq;
    end
  end

  AST_NO_GROUP: assert property (@(posedge mclk) disable iff (rst)
    (!ctrl[`PIE_CTRL_PRIO_EN] && !ctrl[`PIE_CTRL_GROUP]) |=> !irq_high && !irq_low)
    else $error("request forwarded without group enable");
  AST_PRIO_IGNORED: assert property (@(posedge mclk) disable iff (rst)
    !ctrl[`PIE_CTRL_PRIO_EN] |=> !irq_low)
    else $error("low request while priority scheme off");
  AST_EN2_BIT5: assert property (@(posedge mclk) disable iff (rst)
    !en2[5])
    else $error("unimplemented enable bit set");
  AST_WRITE_EN1: assert property (@(posedge mclk) disable iff (rst)
    (wr_go && byteenable[0] && address == `PIE_OFS_ENABLE_1)
      |=> en1 == ($past(writedata[7:0]) & impl1))
    else $error("enable write not stored");
  AST_SMALL_PKG: assert property (@(posedge mclk) disable iff (rst)
    SMALL_PKG |-> !en1[`PIE_PSP_BIT] && prio1[`PIE_PSP_BIT])
    else $error("parallel port bits alive on small package");
  AST_FLAG_SET: assert property (@(posedge mclk) disable iff (rst)
    src_evt_1[0] |=> flg1[0])
    else $error("flag not set by event");
  AST_HIGH_REQ: assert property (@(posedge mclk) disable iff (rst)
    (glb && ctrl[`PIE_CTRL_PRIO_EN] && flg1[0] && en1[0] && prio1[0]) |=> irq_high)
    else $error("high request missing");
  AST_LOW_REQ: assert property (@(posedge mclk) disable iff (rst)
    (glb && ctrl[`PIE_CTRL_PRIO_EN] && |rl1 && !any_h) |=> irq_low)
    else $error("low request missing");
  AST_ACK_ONE: assert property (@(posedge mclk) disable iff (rst)
    !waitrequest |=> waitrequest)
    else $error("ack longer than one cycle");
  // every request seen in idle is answered after exactly one wait state
  AST_ANSWER: assert property (@(posedge mclk) disable iff (rst)
    (st == PIE_IDLE && (read || write)) |=> !waitrequest)
    else $error("request not answered after one wait state");
  // an idle bus keeps the slave stalled, so no stray ack is seen
  AST_IDLE_WAIT: assert property (@(posedge mclk) disable iff (rst)
    (st == PIE_IDLE && !read && !write) |=> waitrequest)
    else $error("ack without a request");
  // second enable register stores written bits, bit 5 stays clear
  AST_WRITE_EN2: assert property (@(posedge mclk) disable iff (rst)
    (wr_go && byteenable[0] && address == `PIE_OFS_ENABLE_2)
      |=> en2 == ($past(writedata[7:0]) & `PIE_EN2_IMPL))
    else $error("enable 2 write not stored");
  // absent parallel priority kept high internally, reads back zero
  AST_WRITE_PRIO: assert property (@(posedge mclk) disable iff (rst)
    (wr_go && byteenable[0] && address == `PIE_OFS_PRIORITY_1)
      |=> prio1 == ($past(writedata[7:0]) | ~impl1))
    else $error("priority write not stored");
  // only global, group and scheme bits of control are kept
  AST_WRITE_CTRL: assert property (@(posedge mclk) disable iff (rst)
    (wr_go && byteenable[0] && address == `PIE_OFS_CONTROL)
      |=> ctrl == ($past(writedata[7:0]) & `PIE_CTRL_IMPL))
    else $error("control write not stored");
  // read and write never share an edge, so the register is stable here
  AST_READ_EN1: assert property (@(posedge mclk) disable iff (rst)
    (rd_go && address == `PIE_OFS_ENABLE_1) |=> readdata == {24'h000000, en1 & impl1})
    else $error("enable 1 readback wrong");
  AST_READ_PRIO: assert property (@(posedge mclk) disable iff (rst)
    (rd_go && address == `PIE_OFS_PRIORITY_1) |=> readdata == {24'h000000, prio1 & impl1})
    else $error("priority readback wrong");
  // compatibility mode forwards on the high line once group enable is on
  AST_SINGLE_REQ: assert property (@(posedge mclk) disable iff (rst)
    (glb && !ctrl[`PIE_CTRL_PRIO_EN] && ctrl[`PIE_CTRL_GROUP] && |rs1) |=> irq_high)
    else $error("compatibility request missing");
  // global enable off silences both vector lines
  AST_NO_GLOBAL: assert property (@(posedge mclk) disable iff (rst)
    !glb |=> !irq_high && !irq_low)
    else $error("request forwarded without global enable");
  // a pending high source always hides the low line
  AST_HIGH_FIRST: assert property (@(posedge mclk) disable iff (rst)
    any_h |=> !irq_low)
    else $error("low request beside a high one");
  // flags only ever fall through a write-one-clear access
  AST_FLAG_HOLD: assert property (@(posedge mclk) disable iff (rst)
    !(wr_go && address == `PIE_OFS_FLAGS)
      |=> (flg1 & $past(flg1)) == $past(flg1) && (flg2 & $past(flg2)) == $past(flg2))
    else $error("flag lost without a clear");
  // status bits are sticky until software clears them
  AST_STATUS_HOLD: assert property (@(posedge mclk) disable iff (rst)
    !(wr_go && address == `PIE_OFS_IRQ_STATUS) |=> (ist & $past(ist)) == $past(ist))
    else $error("status bit lost without a clear");
  // level interrupt follows status and the mask of one cycle earlier
  AST_IRQ_LEVEL: assert property (@(posedge mclk) disable iff (rst)
    irq == |(ist & $past(imask)))
    else $error("interrupt level does not match status and mask");
  COV_HIGH: cover property (@(posedge mclk) disable iff (rst) irq_high);
  COV_LOW:  cover property (@(posedge mclk) disable iff (rst) irq_low);
  COV_IRQ:  cover property (@(posedge mclk) disable iff (rst) irq);
  // compatibility mode request and both priority events recorded
  COV_SINGLE: cover property (@(posedge mclk) disable iff (rst)
    irq_high && !ctrl[`PIE_CTRL_PRIO_EN]);
  COV_BOTH_EVT: cover property (@(posedge mclk) disable iff (rst)
    ist[`PIE_EVT_HIGH] && ist[`PIE_EVT_LOW]);
endmodule

// [core/pie_defs.svh]
// Purpose: register offsets, field positions and reset values for the peripheral irq block
// Assumes: 32-bit avalon data with byte addressing, one register per word
// Notes:   byte addresses given, word index is address divided by four
`ifndef PIE_DEFS_SVH
`define PIE_DEFS_SVH

`define PIE_OFS_ENABLE_1    6'h00
`define PIE_OFS_ENABLE_2    6'h04
`define PIE_OFS_PRIORITY_1  6'h08
`define PIE_OFS_CONTROL     6'h0C
`define PIE_OFS_FLAGS       6'h10
`define PIE_OFS_IRQ_STATUS  6'h14
`define PIE_OFS_IRQ_MASK    6'h18

`define PIE_EN1_RESET       8'h00
`define PIE_EN2_RESET       8'h00
`define PIE_PRIO1_RESET     8'hFF
`define PIE_EN2_IMPL        8'hDF
`define PIE_EN1_IMPL_FULL   8'hFF
`define PIE_EN1_IMPL_SMALL  8'h7F
`define PIE_CTRL_IMPL       8'h83
`define PIE_CTRL_RESET      8'h00
`define PIE_PSP_BIT         7
`define PIE_CTRL_GLOBAL     0
`define PIE_CTRL_GROUP      1
`define PIE_CTRL_PRIO_EN    7
`define PIE_EVT_HIGH        0
`define PIE_EVT_LOW         1
`define PIE_EVT_SINGLE      2
`endif

// [core/pie_gate.sv]
// Purpose: combinational masking of one group of eight sources
// Assumes: flags, enables and priorities share bit positions
// Notes:   no state, the parent registers the results
`timescale 1ns/1ps
`include "pie_defs.svh"
module pie_gate
  import pie_pkg::*;
(
  input  wire logic [7:0] flags,        // source flags
  input  wire logic [7:0] enables,      // per-source enables
  input  wire logic [7:0] prios,        // per-source priority, 1 high
  input  wire logic       prio_en,      // priority scheme on
  input  wire logic       group_en,     // peripheral group enable
  output logic      [7:0] req_high,     // high level requests
  output logic      [7:0] req_low,      // low level requests
  output logic      [7:0] req_single    // compatibility mode requests
);
  // one term per source
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_src
      // priority bit ignored when scheme is off
      assign req_high[i]   = flags[i] & enables[i] & prio_en & prios[i];
      assign req_low[i]    = flags[i] & enables[i] & prio_en & ~prios[i];
      assign req_single[i] = flags[i] & enables[i] & ~prio_en & group_en;
    end
  endgenerate
endmodule

// [core/pie_pkg.sv]
// Purpose: shared types of the peripheral irq block
// Assumes: nothing beyond the defs header
// Notes:   bus answer state and a byte type only
package pie_pkg;
  typedef logic [7:0] pie_byte_t;
  typedef enum logic [0:0] {
    PIE_IDLE = 1'b0,
    PIE_ACK  = 1'b1
  } pie_bus_e;
endpackage

// [tb/pie_src_model.sv]
// Purpose: peripheral condition sources facing the irq block
// Assumes: a condition is a one-cycle pulse launched after a clock edge
// Notes:   idle level is all zero, no source ever holds its line
`timescale 1ns/1ps
module pie_src_model (
  input  wire logic       mclk,      // core clock
  output logic      [7:0] src_evt_1, // group 1 pulses
  output logic      [7:0] src_evt_2  // group 2 pulses
);
  // quiet until a scenario fires a condition
  initial begin
    src_evt_1 = 8'h00;
    src_evt_2 = 8'h00;
  end
  // one pulse, fired whatever the enables hold
  task automatic pulse(input logic [7:0] e1, input logic [7:0] e2);
    @(posedge mclk);
    src_evt_1 <= e1;
    src_evt_2 <= e2;
    @(posedge mclk);
    src_evt_1 <= 8'h00;
    src_evt_2 <= 8'h00;
  endtask
endmodule

// [tb/testbench.sv]
// Purpose: self-checking bench of the peripheral irq masking block
// Assumes: one wait state per access, irq two cycles after a pulse
// Notes:   a small-package copy shares the bus to see the missing bit
`timescale 1ns/1ps
`include "pie_defs.svh"
module testbench;
  logic        mclk;
  logic        rst;
  logic [5:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic [31:0] readdata_s;
  logic        waitrequest;
  logic [7:0]  src_evt_1;
  logic [7:0]  src_evt_2;
  logic        irq_high;
  logic        irq_low;
  logic        irq;
  logic [31:0] rd;
  logic [31:0] rd_s;
  int          num_errors;
  int          n_compared;
  pie_ctrl #(.SMALL_PKG(1'b0)) DUT (.mclk(mclk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .src_evt_1(src_evt_1), .src_evt_2(src_evt_2),
    .irq_high(irq_high), .irq_low(irq_low), .irq(irq));
  // same bus and timing, only the readback is watched
  pie_ctrl #(.SMALL_PKG(1'b1)) dut_small (.mclk(mclk), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata_s), .waitrequest(), .src_evt_1(src_evt_1), .src_evt_2(src_evt_2),
    .irq_high(), .irq_low(), .irq());
  pie_src_model src (.mclk(mclk), .src_evt_1(src_evt_1), .src_evt_2(src_evt_2));
  // 4 ns core clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // avalon access held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rd = readdata;
    rd_s = readdata_s;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      num_errors++;
      $display("ERROR waitrequest expected 0 seen %b", waitrequest);
      tally_and_finish();
    end
  endtask
  task automatic rchk(input string what, input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  task automatic irqs(input logic h, input logic l);
    repeat (3) @(posedge mclk);
    chk("irq_high", {31'h0, h}, {31'h0, irq_high});
    chk("irq_low", {31'h0, l}, {31'h0, irq_low});
  endtask
  task automatic t_reset();
    rchk("en1", `PIE_OFS_ENABLE_1, 32'h00);
    rchk("en2", `PIE_OFS_ENABLE_2, 32'h00);
    rchk("prio1", `PIE_OFS_PRIORITY_1, 32'hFF);
    rchk("unmapped", 6'h1C, 32'h00);
  endtask
  task automatic t_regs();
    bus(1'b1, `PIE_OFS_ENABLE_1, 32'hFF);
    rchk("en1 all", `PIE_OFS_ENABLE_1, 32'hFF);
    chk("small en1", 32'h7F, rd_s);
    bus(1'b1, `PIE_OFS_ENABLE_2, 32'hFF);
    rchk("en2 all", `PIE_OFS_ENABLE_2, 32'hDF);
    bus(1'b1, `PIE_OFS_PRIORITY_1, 32'h00);
    rchk("prio1 low", `PIE_OFS_PRIORITY_1, 32'h00);
    bus(1'b1, `PIE_OFS_PRIORITY_1, 32'hFF);
    rchk("prio1 high", `PIE_OFS_PRIORITY_1, 32'hFF);
    chk("small prio1", 32'h7F, rd_s);
    bus(1'b1, `PIE_OFS_ENABLE_2, 32'h00);
    bus(1'b1, `PIE_OFS_ENABLE_1, 32'h01);
  endtask
  // scheme off: group enable gates, priority ignored
  task automatic t_compat();
    bus(1'b1, `PIE_OFS_CONTROL, 32'h01);
    src.pulse(8'h01, 8'h00);
    irqs(1'b0, 1'b0);
    rchk("flags", `PIE_OFS_FLAGS, 32'h01);
    bus(1'b1, `PIE_OFS_CONTROL, 32'h03);
    irqs(1'b1, 1'b0);
    bus(1'b1, `PIE_OFS_PRIORITY_1, 32'h00);
    irqs(1'b1, 1'b0);
    rchk("status", `PIE_OFS_IRQ_STATUS, 32'h04);
    chk("irq unmasked", 32'h0, {31'h0, irq});
    bus(1'b1, `PIE_OFS_IRQ_MASK, 32'h04);
    repeat (2) @(posedge mclk);
    chk("irq masked in", 32'h1, {31'h0, irq});
    bus(1'b1, `PIE_OFS_FLAGS, 32'hFFFF);
    bus(1'b1, `PIE_OFS_IRQ_STATUS, 32'h07);
    irqs(1'b0, 1'b0);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask
  // scheme on, group enable also set: priority picks the line
  task automatic t_prio();
    bus(1'b1, `PIE_OFS_CONTROL, 32'hFF);
    rchk("ctrl", `PIE_OFS_CONTROL, 32'h83);
    bus(1'b1, `PIE_OFS_ENABLE_1, 32'h03);
    bus(1'b1, `PIE_OFS_PRIORITY_1, 32'h01);
    bus(1'b1, `PIE_OFS_ENABLE_2, 32'h01);
    src.pulse(8'h04, 8'h00);
    irqs(1'b0, 1'b0);
    src.pulse(8'h02, 8'h00);
    irqs(1'b0, 1'b1);
    src.pulse(8'h01, 8'h00);
    irqs(1'b1, 1'b0);
    rchk("status prio", `PIE_OFS_IRQ_STATUS, 32'h03);
    bus(1'b1, `PIE_OFS_FLAGS, 32'hFFFF);
    src.pulse(8'h00, 8'h01);
    irqs(1'b1, 1'b0);
    bus(1'b1, `PIE_OFS_FLAGS, 32'hFFFF);
    irqs(1'b0, 1'b0);
  endtask
  initial begin
    num_errors = 0;
    n_compared = 0;
    rst = 1'b1;
    address = 6'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'hF;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_compat();
    t_prio();
    tally_and_finish();
  end
endmodule
